// ### bcm_analog.sv
`timescale 1ns/1ps
// Comparators and current source seen by the mode controller
module bcm_analog #(
    parameter int FAST_HI_MV = 3000,
    parameter int FAST_LO_MV = 2900,
    parameter int FLOAT_MV = 4200,
    parameter int RECH_MV = 4100
) (
    input wire logic [15:0] batt_mv,
    input wire logic [15:0] vin_mv,
    input wire logic [15:0] taper_ma,
    input wire logic charger_on,
    input wire logic cv_regulate,
    input wire logic [7:0] current_cmd_ma,
    output logic hi,
    output logic lo,
    output logic flt,
    output logic rch,
    output logic trm,
    output logic inl
);
    // Fixed thresholds, two points give the hysteresis band
    assign hi = int'(batt_mv) > FAST_HI_MV;
    assign lo = int'(batt_mv) > FAST_LO_MV;
    assign flt = int'(batt_mv) >= FLOAT_MV;
    assign rch = int'(batt_mv) < RECH_MV;
    // Delivered current tapers only while regulating voltage
    assign trm = !charger_on || (cv_regulate && int'(taper_ma) * 10 < int'(current_cmd_ma));
    assign inl = int'(batt_mv) > int'(vin_mv) - 50;
endmodule : bcm_analog

// ### bcm_ctrl.sv
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "bcm_params.svh"
//
// Behaviour
// - Reset starts disabled with no current commanded
// - Exactly five modes: disabled, trickle, fast, standby, error
// - Enable low forces disabled, all sources off
// - Below fast threshold: trickle at tenth current
// - Fast threshold compare uses hysteresis
// - Above threshold: fast current, 10 to 200mA
// - Constant current until float, then constant voltage
// - Current below termination ends charge, standby
// - Standby returns to fast below recharge level
// - Battery above input minus 50mV: error
// - Error clears by itself when input recovers
// - Any-cycle transitions; thresholds fixed and calibrated
// - Trim from nonvolatile default, key overrides
//
module bcm_ctrl #(
    parameter int TRIM_W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Analogue comparator outputs (asynchronous)
    input wire logic cmp_above_fast_hi,
    input wire logic cmp_above_fast_lo,
    input wire logic cmp_at_float,
    input wire logic cmp_below_recharge,
    input wire logic cmp_below_term,
    input wire logic cmp_input_low,
    // Production trim default from nonvolatile storage
    input wire logic [TRIM_W-1:0] nvm_trim_default,
    // Current source control, mode and interrupt
    output logic charger_on,
    output logic [7:0] current_cmd_ma,
    output logic cv_regulate,
    output logic [TRIM_W-1:0] trim_out,
    output bcm_pkg::bcm_mode_type mode,
    output logic irq
);
    import bcm_pkg::*;

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [5:0] cmp_sync; // Synchronised comparator levels
    logic above_fast_hi; // Battery above upper fast threshold
    logic above_fast_lo; // Battery above lower fast threshold
    logic at_float; // Battery at float voltage
    logic below_recharge; // Battery below float minus recharge hysteresis
    logic below_term; // Delivered current below termination
    logic input_low; // Charger input too low
    bcm_mode_type mode_ff; // Current mode
    bcm_mode_type nxt_mode; // Next mode
    logic enable_ff; // Software enable
    logic [7:0] fast_ma_ff; // Programmed fast current
    logic [TRIM_W-1:0] trim_key_ff; // Key trim value
    logic trim_ovr_ff; // Key trim present
    logic [3:0] mask_ff; // Interrupt mask
    logic [3:0] ev_status; // Sticky event bits
    logic [3:0] events; // Event pulses this cycle
    logic istat_clear; // Read of event status completing
    logic pready_ff; // Access phase answer
    logic pslverr_ff; // Error answer
    logic [31:0] prdata_ff; // Read data
    logic charger_on_ff; // Current source enabled
    logic [7:0] current_ff; // Commanded current
    logic cv_ff; // Constant-voltage regulation
    logic [TRIM_W-1:0] trim_ff; // Trim in force
    logic acc_done; // Transfer completes on this edge
    logic wr_done; // Write completes on this edge
    logic rd_done; // Read completes on this edge

    // ----------------------------------------
    // Decoding helpers
    // ----------------------------------------
    // True when the offset names a mapped register
    function automatic logic addr_mapped(input logic [11:0] a);
        addr_mapped = (a == `BCM_OFF_CTRL) || (a == `BCM_OFF_FAST) ||
                      (a == `BCM_OFF_TRIM) || (a == `BCM_OFF_STAT) ||
                      (a == `BCM_OFF_ISTAT) || (a == `BCM_OFF_IMASK);
    endfunction : addr_mapped

    // Limit a programmed fast current to its legal span
    function automatic logic [7:0] clamp_fast(input logic [7:0] v);
        if (v < `BCM_FAST_MIN_MA) begin
            clamp_fast = `BCM_FAST_MIN_MA;
        end else if (v > `BCM_FAST_MAX_MA) begin
            clamp_fast = `BCM_FAST_MAX_MA;
        end else begin
            clamp_fast = v;
        end
    endfunction : clamp_fast

    // True for modes that source current
    function automatic logic mode_charging(input bcm_mode_type m);
        mode_charging = (m == BCM_TRICKLE) || (m == BCM_FAST);
    endfunction : mode_charging

    // ----------------------------------------
    // Comparator synchroniser
    // ----------------------------------------
    bcm_sync #(
        .WIDTH(6)
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_in({cmp_input_low, cmp_below_term, cmp_below_recharge,
                   cmp_at_float, cmp_above_fast_lo, cmp_above_fast_hi}),
        .sync_out(cmp_sync)
    );

    assign above_fast_hi = cmp_sync[0];
    assign above_fast_lo = cmp_sync[1];
    assign at_float = cmp_sync[2];
    assign below_recharge = cmp_sync[3];
    assign below_term = cmp_sync[4];
    assign input_low = cmp_sync[5];

    // ----------------------------------------
    // Mode selection
    // ----------------------------------------
    // Evaluated every cycle from fixed comparator levels
    always_comb begin
        nxt_mode = mode_ff;
        if (!enable_ff) begin
            nxt_mode = BCM_DISABLED;
        end else if (input_low) begin
            nxt_mode = BCM_ERROR;
        end else begin
            case (mode_ff)
                // Start or resume from threshold position
                BCM_DISABLED, BCM_ERROR: begin
                    nxt_mode = above_fast_hi ? BCM_FAST : BCM_TRICKLE;
                end
                // Leave trickle only above the upper threshold
                BCM_TRICKLE: begin
                    if (above_fast_hi) begin
                        nxt_mode = BCM_FAST;
                    end
                end
                // Drop back only below the lower threshold
                BCM_FAST: begin
                    if (!above_fast_lo) begin
                        nxt_mode = BCM_TRICKLE;
                    end else if (at_float && below_term) begin
                        nxt_mode = BCM_STANDBY;
                    end
                end
                // Recharge when battery sags
                BCM_STANDBY: begin
                    if (below_recharge) begin
                        nxt_mode = BCM_FAST;
                    end
                end
                default: begin
                    nxt_mode = BCM_DISABLED;
                end
            endcase
        end
    end

    // Mode register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_ff <= BCM_DISABLED;
        end else begin
            mode_ff <= nxt_mode;
        end
    end

    // ----------------------------------------
    // Current source command
    // ----------------------------------------
    // Registered from the next mode so commands track the mode register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            charger_on_ff <= 1'b0;
            current_ff <= 8'h00;
            cv_ff <= 1'b0;
        end else begin
            charger_on_ff <= mode_charging(nxt_mode);
            cv_ff <= (nxt_mode == BCM_FAST) && at_float;
            case (nxt_mode)
                BCM_TRICKLE: begin
                    current_ff <= fast_ma_ff / `BCM_TRICKLE_DIV;
                end
                BCM_FAST: begin
                    current_ff <= fast_ma_ff;
                end
                default: begin
                    current_ff <= 8'h00;
                end
            endcase
        end
    end

    // Trim in force: key value when present, else production default
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trim_ff <= '0;
        end else begin
            trim_ff <= trim_ovr_ff ? trim_key_ff : nvm_trim_default;
        end
    end

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    assign acc_done = psel && penable && pready_ff;
    assign wr_done = acc_done && pwrite && addr_mapped(paddr);
    assign rd_done = acc_done && !pwrite;
    assign istat_clear = rd_done && (paddr == `BCM_OFF_ISTAT);

    // One wait cycle, then answer with data and error flag
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= psel && penable && !pready_ff;
            pslverr_ff <= psel && penable && !pready_ff && !addr_mapped(paddr);
        end
    end

    // Read data captured with the answer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_ff <= 32'h0000_0000;
        end else if (psel && penable && !pready_ff && !pwrite) begin
            case (paddr)
                `BCM_OFF_CTRL: prdata_ff <= {31'h0, enable_ff};
                `BCM_OFF_FAST: prdata_ff <= {24'h0, fast_ma_ff};
                `BCM_OFF_TRIM: prdata_ff <= {23'h0, trim_ovr_ff, trim_key_ff};
                `BCM_OFF_STAT: prdata_ff <= {22'h0, cmp_sync, 1'b0, mode_ff};
                `BCM_OFF_ISTAT: prdata_ff <= {28'h0, ev_status};
                `BCM_OFF_IMASK: prdata_ff <= {28'h0, mask_ff};
                default: prdata_ff <= 32'h0000_0000;
            endcase
        end else begin
            prdata_ff <= 32'h0000_0000;
        end
    end

    // Enable register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_ff <= 1'b0;
        end else if (wr_done && paddr == `BCM_OFF_CTRL) begin
            enable_ff <= pwdata[`BCM_CTRL_EN_BIT];
        end
    end

    // Fast current register, clamped to legal span
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fast_ma_ff <= `BCM_FAST_RST;
        end else if (wr_done && paddr == `BCM_OFF_FAST) begin
            fast_ma_ff <= clamp_fast(pwdata[7:0]);
        end
    end

    // Trim key register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trim_key_ff <= '0;
            trim_ovr_ff <= 1'b0;
        end else if (wr_done && paddr == `BCM_OFF_TRIM) begin
            trim_key_ff <= pwdata[TRIM_W-1:0];
            trim_ovr_ff <= pwdata[`BCM_TRIM_OVR_BIT];
        end
    end

    // Interrupt mask register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_ff <= `BCM_MASK_RST;
        end else if (wr_done && paddr == `BCM_OFF_IMASK) begin
            mask_ff <= pwdata[3:0];
        end
    end

    // ----------------------------------------
    // Events and interrupt
    // ----------------------------------------
    always_comb begin
        events = 4'h0;
        events[`BCM_EV_CHANGE_BIT] = (nxt_mode != mode_ff);
        events[`BCM_EV_ERROR_BIT] = (nxt_mode == BCM_ERROR) && (mode_ff != BCM_ERROR);
        events[`BCM_EV_STANDBY_BIT] = (nxt_mode == BCM_STANDBY) && (mode_ff != BCM_STANDBY);
        events[`BCM_EV_RECOVER_BIT] = (mode_ff == BCM_ERROR) && (nxt_mode != BCM_ERROR);
        // Re-set bits that arrived after the read snapshot so the read-clear cannot lose them
        events = events | (istat_clear ? (ev_status & ~prdata_ff[3:0]) : 4'h0);
    end

    bcm_irq #(
        .NEV(4)
    ) u_irq (
        .clk(clk),
        .rst_n(rst_n),
        .event_in(events),
        .mask(mask_ff),
        .clear(istat_clear),
        .status(ev_status),
        .irq(irq)
    );

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign charger_on = charger_on_ff;
    assign current_cmd_ma = current_ff;
    assign cv_regulate = cv_ff;
    assign trim_out = trim_ff;
    assign mode = mode_ff;
endmodule : bcm_ctrl

// ### bcm_ctrl_chk.sv
`timescale 1ns/1ps
module bcm_ctrl_chk
    import bcm_pkg::*;
#(
    parameter int TRIM_W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic cmp_above_fast_hi,
    input wire logic cmp_above_fast_lo,
    input wire logic cmp_at_float,
    input wire logic cmp_below_recharge,
    input wire logic cmp_below_term,
    input wire logic cmp_input_low,
    input wire logic [TRIM_W-1:0] nvm_trim_default,
    input wire logic charger_on,
    input wire logic [7:0] current_cmd_ma,
    input wire logic cv_regulate,
    input wire logic [TRIM_W-1:0] trim_out,
    input wire bcm_pkg::bcm_mode_type mode,
    input wire logic irq
);
    // ----------------------------------------
    // Mode and current checks
    // ----------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_start_off: assert property ($rose(rst_n) |-> mode == BCM_DISABLED && !charger_on)
        else $error("mode not disabled after reset");
    a_mode_legal: assert property (mode <= BCM_ERROR)
        else $error("illegal mode code");
    a_off_no_cur: assert property (mode == BCM_DISABLED |-> !charger_on && current_cmd_ma == 8'h00)
        else $error("current while disabled");
    a_trickle_cur: assert property (mode == BCM_TRICKLE |-> charger_on && current_cmd_ma inside {[8'h01:8'h14]})
        else $error("trickle current out of range");
    a_hyst_low: assert property ((!cmp_above_fast_lo && !cmp_input_low)[*7] |-> mode != BCM_FAST)
        else $error("fast mode below lower point");
    a_fast_cur: assert property (mode == BCM_FAST && !cv_regulate |-> current_cmd_ma inside {[8'h0a:8'hc8]})
        else $error("fast current out of range");
    a_cv_fast: assert property (cv_regulate |-> mode == BCM_FAST && charger_on)
        else $error("voltage regulation outside fast mode");
    a_term_stop: assert property ((cmp_at_float && cmp_below_term && !cmp_input_low)[*7] |-> mode != BCM_FAST)
        else $error("fast mode kept below termination");
    a_stby_exit: assert property ((cmp_below_recharge && !cmp_input_low)[*7] |-> mode != BCM_STANDBY)
        else $error("standby kept below recharge level");
    a_err_stop: assert property (mode == BCM_ERROR |-> !charger_on && current_cmd_ma == 8'h00)
        else $error("current while in error");
    a_err_leave: assert property ((!cmp_input_low)[*7] |-> mode != BCM_ERROR)
        else $error("error kept after input recovered");
    a_err_prio: assert property (cmp_input_low[*7] |-> mode inside {BCM_ERROR, BCM_DISABLED})
        else $error("charging while input low");
endmodule : bcm_ctrl_chk

bind bcm_ctrl bcm_ctrl_chk #(.TRIM_W(TRIM_W)) u_chk (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmp_above_fast_hi(cmp_above_fast_hi), .cmp_above_fast_lo(cmp_above_fast_lo), .cmp_at_float(cmp_at_float),
    .cmp_below_recharge(cmp_below_recharge), .cmp_below_term(cmp_below_term), .cmp_input_low(cmp_input_low),
    .nvm_trim_default(nvm_trim_default), .charger_on(charger_on), .current_cmd_ma(current_cmd_ma),
    .cv_regulate(cv_regulate), .trim_out(trim_out), .mode(mode), .irq(irq));

// ### bcm_ctrl_tb.sv
`timescale 1ns/1ps
`include "bcm_params.svh"
module bcm_ctrl_tb;
    import bcm_pkg::*;
    typedef struct {logic [31:0] dat; logic [31:0] msk; logic err;} bcm_note_type;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, charger_on, cv_regulate, irq;
    logic hi, lo, flt, rch, trm, inl;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0] current_cmd_ma, trim_out, nvm_trim, v;
    logic [7:0] tbl [4] = '{8'h05, 8'h0a, 8'hc8, 8'hc9};
    logic [15:0] batt_mv, vin_mv, taper_ma;
    bcm_mode_type mode;
    bcm_note_type notes[$];
    bcm_note_type nt;
    int err_count, n_compared, seed;
    // ----------------------------------------
    // Clock, design and far side
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    bcm_ctrl dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmp_above_fast_hi(hi),
        .cmp_above_fast_lo(lo), .cmp_at_float(flt), .cmp_below_recharge(rch), .cmp_below_term(trm),
        .cmp_input_low(inl), .nvm_trim_default(nvm_trim), .charger_on(charger_on), .current_cmd_ma(current_cmd_ma),
        .cv_regulate(cv_regulate), .trim_out(trim_out), .mode(mode), .irq(irq));
    bcm_analog u_ana (.batt_mv(batt_mv), .vin_mv(vin_mv), .taper_ma(taper_ma), .charger_on(charger_on),
        .cv_regulate(cv_regulate), .current_cmd_ma(current_cmd_ma), .hi(hi), .lo(lo), .flt(flt), .rch(rch),
        .trm(trm), .inl(inl));
    // ----------------------------------------
    // Reporting and bus tasks
    // ----------------------------------------
    task automatic conclude;
        if (err_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude
    task automatic cmp_port(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp_port
    // One APB transfer; the expected answer is noted first
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e,
        input logic [31:0] m, input logic er);
        int n;
        notes.push_back('{e, m, er});
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            err_count++;
            conclude();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 32'hffffffff, 1'b0);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
        apb(1'b0, a, 32'h0, e, m, 1'b0);
    endtask : rd
    // Bounded wait for a mode
    task automatic wait_mode(input bcm_mode_type m);
        int n;
        n = 0;
        while (mode !== m && n < 40) begin
            @(posedge clk);
            n++;
        end
        cmp_port("mode", 32'(m), 32'(mode));
        if (mode !== m) conclude();
    endtask : wait_mode
    // Bus answers are matched against the oldest note
    always @(posedge clk) begin
        if (rst_n && pready === 1'b1 && notes.size() > 0) begin
            nt = notes.pop_front();
            cmp_port("prdata", nt.dat & nt.msk, prdata & nt.msk);
            cmp_port("pslverr", 32'(nt.err), 32'(pslverr));
        end
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        seed = 32'h6372;
        err_count = 0;
        n_compared = 0;
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        nvm_trim = 8'h5a;
        batt_mv = 16'd2500;
        vin_mv = 16'd5000;
        taper_ma = 16'd100;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        cmp_port("charger_on", 32'h0, 32'(charger_on));
        rd(`BCM_OFF_CTRL, 32'h0, 32'hffffffff);
        rd(`BCM_OFF_FAST, 32'h64, 32'hffffffff);
        rd(`BCM_OFF_IMASK, 32'h0, 32'hffffffff);
        apb(1'b0, 12'h018, 32'h0, 32'h0, 32'hffffffff, 1'b1);
        apb(1'b1, 12'h018, 32'h1, 32'h0, 32'hffffffff, 1'b1);
        cmp_port("trim_out", 32'(nvm_trim), 32'(trim_out));
        for (int i = 0; i < 8; i++) begin
            v = (i < 4) ? tbl[i] : 8'($random(seed));
            wr(`BCM_OFF_FAST, 32'(v));
            rd(`BCM_OFF_FAST, (v < 8'h0a) ? 32'h0a : (v > 8'hc8) ? 32'hc8 : 32'(v), 32'hff);
        end
        wr(`BCM_OFF_FAST, 32'd150);
        wr(`BCM_OFF_CTRL, 32'h1);
        wait_mode(BCM_TRICKLE);
        cmp_port("current", 32'd15, 32'(current_cmd_ma));
        batt_mv <= 16'd2950;
        repeat (8) @(posedge clk);
        cmp_port("mode", 32'(BCM_TRICKLE), 32'(mode));
        batt_mv <= 16'd3100;
        wait_mode(BCM_FAST);
        cmp_port("current", 32'd150, 32'(current_cmd_ma));
        batt_mv <= 16'd2950;
        repeat (8) @(posedge clk);
        cmp_port("mode", 32'(BCM_FAST), 32'(mode));
        batt_mv <= 16'd2800;
        wait_mode(BCM_TRICKLE);
        rd(`BCM_OFF_STAT, 32'h1, 32'h7);
        rd(`BCM_OFF_ISTAT, 32'h1, 32'hf);
        wr(`BCM_OFF_IMASK, 32'h4);
        batt_mv <= 16'd4250;
        wait_mode(BCM_FAST);
        repeat (2) @(posedge clk);
        cmp_port("cv_regulate", 32'h1, 32'(cv_regulate));
        taper_ma <= 16'd10;
        wait_mode(BCM_STANDBY);
        cmp_port("charger_on", 32'h0, 32'(charger_on));
        repeat (2) @(posedge clk);
        cmp_port("irq", 32'h1, 32'(irq));
        rd(`BCM_OFF_ISTAT, 32'h5, 32'hf);
        repeat (2) @(posedge clk);
        cmp_port("irq", 32'h0, 32'(irq));
        batt_mv <= 16'd4050;
        wait_mode(BCM_FAST);
        vin_mv <= 16'd4000;
        wait_mode(BCM_ERROR);
        cmp_port("current", 32'h0, 32'(current_cmd_ma));
        cmp_port("irq", 32'h0, 32'(irq));
        vin_mv <= 16'd5000;
        wait_mode(BCM_FAST);
        rd(`BCM_OFF_ISTAT, 32'hb, 32'hf);
        wr(`BCM_OFF_TRIM, 32'h1ab);
        repeat (2) @(posedge clk);
        cmp_port("trim_out", 32'hab, 32'(trim_out));
        wr(`BCM_OFF_CTRL, 32'h0);
        wait_mode(BCM_DISABLED);
        cmp_port("current", 32'h0, 32'(current_cmd_ma));
        // Reset in mid-charge must return to disabled with defaults
        wr(`BCM_OFF_CTRL, 32'h1);
        wait_mode(BCM_FAST);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        cmp_port("charger_on", 32'h0, 32'(charger_on));
        cmp_port("mode", 32'(BCM_DISABLED), 32'(mode));
        rst_n <= 1'b1;
        rd(`BCM_OFF_CTRL, 32'h0, 32'hffffffff);
        cmp_port("trim_out", 32'(nvm_trim), 32'(trim_out));
        repeat (3) @(posedge clk);
        conclude();
    end
endmodule : bcm_ctrl_tb

// ### bcm_irq.sv
`timescale 1ns/1ps
// Sticky event status with mask; read clears, a new event wins over the clear
module bcm_irq #(
    parameter int NEV = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [NEV-1:0] event_in,
    input wire logic [NEV-1:0] mask,
    input wire logic clear,
    output logic [NEV-1:0] status,
    output logic irq
);
    import bcm_pkg::*;
    logic [NEV-1:0] status_ff; // Sticky event bits
    logic irq_ff; // Registered interrupt level
    // ----------------------------------------
    // Sticky bits
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status_ff <= '0;
        end else begin
            status_ff <= (clear ? '0 : status_ff) | event_in;
        end
    end
    // Interrupt level, registered on the same edge as the status bits
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(((clear ? '0 : status_ff) | event_in) & mask);
        end
    end
    assign status = status_ff;
    assign irq = irq_ff;
endmodule : bcm_irq

// ### bcm_params.svh
`ifndef BCM_PARAMS_SVH
`define BCM_PARAMS_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define BCM_OFF_CTRL 12'h000
`define BCM_OFF_FAST 12'h004
`define BCM_OFF_TRIM 12'h008
`define BCM_OFF_STAT 12'h00c
`define BCM_OFF_ISTAT 12'h010
`define BCM_OFF_IMASK 12'h014
// ----------------------------------------
// Field positions
// ----------------------------------------
`define BCM_CTRL_EN_BIT 0
`define BCM_TRIM_OVR_BIT 8
`define BCM_STAT_CMP_LSB 4
`define BCM_EV_CHANGE_BIT 0
`define BCM_EV_ERROR_BIT 1
`define BCM_EV_STANDBY_BIT 2
`define BCM_EV_RECOVER_BIT 3
// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define BCM_FAST_RST 8'h64
`define BCM_FAST_MIN_MA 8'h0a
`define BCM_FAST_MAX_MA 8'hc8
`define BCM_TRICKLE_DIV 8'h0a
`define BCM_MASK_RST 4'h0
`define BCM_ERR_MARGIN_MV 50
`endif

// ### bcm_pkg.sv
package bcm_pkg;
    // Charger operating mode
    typedef enum logic [2:0] {
        BCM_DISABLED = 3'b000,
        BCM_TRICKLE = 3'b001,
        BCM_FAST = 3'b010,
        BCM_STANDBY = 3'b011,
        BCM_ERROR = 3'b100
    } bcm_mode_type;
endpackage : bcm_pkg

// ### bcm_sync.sv
`timescale 1ns/1ps
// Three-stage synchroniser; a change is accepted once stages two and three agree
module bcm_sync #(
    parameter int WIDTH = 6
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    // ----------------------------------------
    // Per-bit stages
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
            logic s1_ff; // First stage, read only by the second
            logic s2_ff; // Second stage
            logic s3_ff; // Third stage
            logic out_ff; // Accepted level
            // Shift chain
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    s1_ff <= 1'b0;
                    s2_ff <= 1'b0;
                    s3_ff <= 1'b0;
                end else begin
                    s1_ff <= async_in[gi];
                    s2_ff <= s1_ff;
                    s3_ff <= s2_ff;
                end
            end
            // Accept only when the two settled stages agree
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    out_ff <= 1'b0;
                end else if (s2_ff == s3_ff) begin
                    out_ff <= s3_ff;
                end
            end
            assign sync_out[gi] = out_ff;
        end
    endgenerate
endmodule : bcm_sync
